// *** core/pin_mux_pkg.sv ***
`default_nettype none
package pin_mux_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PIN_N = 4;
    localparam int FRAMER_N = 2;
    localparam int FIRST = 0;
    localparam int SECOND = 1;

    // Register byte addresses on the control port
    localparam logic [7:0] ADDR_FIRST_CTRL = 8'h11;
    localparam logic [7:0] ADDR_SECOND_CTRL = 8'hB1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Fields shared by both registers
    localparam int TEST_MUX_BIT = 5;
    localparam int PIN_FUNC_BIT = 1;
    localparam int IDLE_FUNC_BIT = 0;
    // First framer only
    localparam int LINE_EDGE_BIT = 7;
    localparam int PAYLOAD_EDGE_BIT = 6;
    localparam int ALARM_FORCE_BIT = 4;
    localparam int LINE_DISC_BIT = 2;
    // Second framer only
    localparam int RX_INV_BIT = 7;
    localparam int TX_INV_BIT = 6;
    localparam int FRAMER_DISC_BIT = 2;

    // Forced line-side levels while the alarm is forced
    localparam logic ALARM_NRZ_LEVEL = 1'b1;
    localparam logic ALARM_SYNC_LEVEL = 1'b0;
endpackage
`default_nettype wire

// *** core/pin_mux_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pin_mux_if;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] value;
    modport owner (input wr, input wdata, output value);
    modport user (output wr, output wdata, input value);
endinterface
`default_nettype wire

// *** core/pin_mux_ctrl_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_mux_ctrl_reg (
    input wire logic clk_i,
    input wire logic rst_b_i,
    pin_mux_if.owner port_if
);
    typedef struct packed {
        logic [7:0] value;
    } reg_state_t;

    reg_state_t st;
    reg_state_t next_st;

    always_comb begin
        next_st = st;
        if (port_if.wr) begin
            next_st.value = port_if.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '{value: pin_mux_pkg::CTRL_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign port_if.value = st.value;

    chk_write_stores: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        port_if.wr |=> st.value == $past(port_if.wdata))
        else $error("control register did not take written value");
endmodule // pin_mux_ctrl_reg
`default_nettype wire

// *** core/framer_pin_and_mux_control.sv ***
// Overview of operation
// - With the first framer's bit 7 clear, line-side data update on the rising line clock edge, set on the falling edge.
// - With the first framer's bit 6 clear, payload data are sampled on the falling payload clock edge, set on the rising edge.
// - In each framer bit 5 set enables the transmit test-pattern mux, clear disables it.
// - The first framer's bit 4 set holds line NRZ output at 1 and line frame sync at 0; clear lets both run normally.
// - The first framer's bit 2 clear links the line interface to the first framer on chip, set breaks that link.
// - In each framer bit 1 selects the four shared pins: clear gives channel clock and block, set gives link clock and data.
// - In each framer bit 0 clear makes the idle table pick the channels that get the idle code.
// - In each framer bit 0 set makes the idle table pick the channels that carry the framer's receive serial data.
// - In the second framer bit 7 inverts the receive clock input and bit 6 the transmit clock output.
// - The second framer's bit 2 clear links the first framer to the second on chip, set breaks that link.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module framer_pin_and_mux_control (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic line_side_clock_i,
    input wire logic line_nrz_src_i,
    input wire logic line_sync_src_i,
    output logic line_side_nrz_output_o,
    output logic line_side_frame_sync_o,
    input wire logic payload_clock_i,
    input wire logic payload_data_i,
    output logic payload_sample_o,
    input wire logic liu_rx_data_i,
    input wire logic first_ext_data_i,
    output logic first_framer_line_o,
    input wire logic first_framer_out_i,
    input wire logic second_ext_data_i,
    output logic second_framer_in_o,
    input wire logic second_rx_clock_in_i,
    input wire logic second_tx_clock_src_i,
    output logic second_rx_clock_o,
    output logic second_tx_clock_out_o,
    input wire logic [1:0] tx_payload_i,
    input wire logic [1:0] test_pattern_i,
    input wire logic [1:0] idle_table_hit_i,
    input wire logic [1:0] idle_code_bit_i,
    input wire logic [1:0] rx_serial_i,
    output logic [1:0] tx_data_o,
    input wire logic [1:0][3:0] channel_pins_i,
    input wire logic [1:0][3:0] link_pins_i,
    output logic [1:0][3:0] shared_pins_o
);

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    pin_mux_if first_if ();
    pin_mux_if second_if ();

    assign first_if.wr = wr_i && (addr_i == pin_mux_pkg::ADDR_FIRST_CTRL);
    assign first_if.wdata = wdata_i;
    assign second_if.wr = wr_i && (addr_i == pin_mux_pkg::ADDR_SECOND_CTRL);
    assign second_if.wdata = wdata_i;

    pin_mux_ctrl_reg first_reg (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .port_if(first_if)
    );

    pin_mux_ctrl_reg second_reg (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .port_if(second_if)
    );

    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [1:0][7:0] cfg;

    assign cfg_a = first_if.value;
    assign cfg_b = second_if.value;
    assign cfg[pin_mux_pkg::FIRST] = cfg_a;
    assign cfg[pin_mux_pkg::SECOND] = cfg_b;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Edge seen between the held previous level and the current level
    function automatic logic edge_hit(input logic prev, input logic now,
                                      input logic falling);
        edge_hit = falling ? (prev && !now) : (!prev && now);
    endfunction

    // Transmit source for one framer: idle table first, then test pattern
    function automatic logic tx_pick(input logic [7:0] c, input logic pay,
                                     input logic pat, input logic hit,
                                     input logic idle, input logic rxs);
        logic v;
        v = pay;
        if (hit) begin
            v = c[pin_mux_pkg::IDLE_FUNC_BIT] ? rxs : idle;
        end
        if (c[pin_mux_pkg::TEST_MUX_BIT]) begin
            v = pat;
        end
        tx_pick = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Block state

    typedef struct packed {
        logic prev_line_side_clock;
        logic prev_pclk;
        logic nrz;
        logic fsync;
        logic psample;
        logic a_line;
        logic b_in;
        logic rx_clk;
        logic tx_clk;
        logic [1:0] tx;
        logic [1:0][3:0] pins;
        logic [7:0] rdata;
    } blk_state_t;

    blk_state_t st;
    blk_state_t next_st;

    logic line_edge;
    logic pay_edge;

    assign line_edge = edge_hit(st.prev_line_side_clock, line_side_clock_i,
                                cfg_a[pin_mux_pkg::LINE_EDGE_BIT]);
    assign pay_edge = edge_hit(st.prev_pclk, payload_clock_i,
                               !cfg_a[pin_mux_pkg::PAYLOAD_EDGE_BIT]);

    always_comb begin
        next_st = st;
        next_st.prev_line_side_clock = line_side_clock_i;
        next_st.prev_pclk = payload_clock_i;

        // Line clock is sampled, so updates land one cycle after the edge
        if (line_edge) begin
            next_st.nrz = line_nrz_src_i;
            next_st.fsync = line_sync_src_i;
        end
        // Forcing wins at once rather than waiting for a line clock edge
        if (cfg_a[pin_mux_pkg::ALARM_FORCE_BIT]) begin
            next_st.nrz = pin_mux_pkg::ALARM_NRZ_LEVEL;
            next_st.fsync = pin_mux_pkg::ALARM_SYNC_LEVEL;
        end

        if (pay_edge) begin
            next_st.psample = payload_data_i;
        end

        next_st.a_line = cfg_a[pin_mux_pkg::LINE_DISC_BIT] ?
            first_ext_data_i : liu_rx_data_i;
        next_st.b_in = cfg_b[pin_mux_pkg::FRAMER_DISC_BIT] ?
            second_ext_data_i : first_framer_out_i;

        next_st.rx_clk = second_rx_clock_in_i ^
            cfg_b[pin_mux_pkg::RX_INV_BIT];
        next_st.tx_clk = second_tx_clock_src_i ^
            cfg_b[pin_mux_pkg::TX_INV_BIT];

        for (int f = 0; f < pin_mux_pkg::FRAMER_N; f++) begin
            next_st.tx[f] = tx_pick(cfg[f], tx_payload_i[f],
                test_pattern_i[f], idle_table_hit_i[f],
                idle_code_bit_i[f], rx_serial_i[f]);
            next_st.pins[f] = cfg[f][pin_mux_pkg::PIN_FUNC_BIT] ?
                link_pins_i[f] : channel_pins_i[f];
        end

        // Read data stand only in the cycle after the strobe
        next_st.rdata = pin_mux_pkg::READ_IDLE;
        if (rd_i) begin
            case (addr_i)
                pin_mux_pkg::ADDR_FIRST_CTRL: begin
                    next_st.rdata = cfg_a;
                end
                pin_mux_pkg::ADDR_SECOND_CTRL: begin
                    next_st.rdata = cfg_b;
                end
                default: begin
                    next_st.rdata = pin_mux_pkg::READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign line_side_nrz_output_o = st.nrz;
    assign line_side_frame_sync_o = st.fsync;
    assign payload_sample_o = st.psample;
    assign first_framer_line_o = st.a_line;
    assign second_framer_in_o = st.b_in;
    assign second_rx_clock_o = st.rx_clk;
    assign second_tx_clock_out_o = st.tx_clk;
    assign tx_data_o = st.tx;
    assign shared_pins_o = st.pins;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_line_rise_update: assert property (
        !cfg_a[pin_mux_pkg::LINE_EDGE_BIT] &&
        !cfg_a[pin_mux_pkg::ALARM_FORCE_BIT] &&
        !st.prev_line_side_clock && line_side_clock_i
        |=> line_side_nrz_output_o == $past(line_nrz_src_i))
        else $error("line data not updated on rising edge");

    chk_line_hold_noedge: assert property (
        !line_edge && !cfg_a[pin_mux_pkg::ALARM_FORCE_BIT]
        ##1 !cfg_a[pin_mux_pkg::ALARM_FORCE_BIT]
        |-> $stable(line_side_frame_sync_o))
        else $error("line sync changed without a selected edge");

    chk_payload_edge: assert property (
        pay_edge |=> payload_sample_o == $past(payload_data_i))
        else $error("payload data not sampled on selected edge");

    chk_test_mux_on: assert property (
        cfg_b[pin_mux_pkg::TEST_MUX_BIT]
        |=> tx_data_o[pin_mux_pkg::SECOND] ==
            $past(test_pattern_i[pin_mux_pkg::SECOND]))
        else $error("test pattern not on transmit data");

    chk_alarm_levels: assert property (
        cfg_a[pin_mux_pkg::ALARM_FORCE_BIT] [*2]
        |-> line_side_nrz_output_o && !line_side_frame_sync_o)
        else $error("forced alarm levels not held");

    // Gated by reset so the edge that releases it judges no forced zeros
    chk_line_route: assert property (
        rst_b_i && !cfg_a[pin_mux_pkg::LINE_DISC_BIT]
        |=> first_framer_line_o == $past(liu_rx_data_i))
        else $error("line interface not routed to first framer");

    chk_line_disconnect: assert property (
        cfg_a[pin_mux_pkg::LINE_DISC_BIT]
        |=> first_framer_line_o == $past(first_ext_data_i))
        else $error("line interface link not broken");

    chk_pin_function: assert property (
        cfg_a[pin_mux_pkg::PIN_FUNC_BIT]
        |=> shared_pins_o[pin_mux_pkg::FIRST] ==
            $past(link_pins_i[pin_mux_pkg::FIRST]))
        else $error("shared pins not in link mode");

    chk_pin_channel: assert property (
        rst_b_i && !cfg_b[pin_mux_pkg::PIN_FUNC_BIT]
        |=> shared_pins_o[pin_mux_pkg::SECOND] ==
            $past(channel_pins_i[pin_mux_pkg::SECOND]))
        else $error("shared pins not in channel mode");

    chk_test_mux_first: assert property (
        cfg_a[pin_mux_pkg::TEST_MUX_BIT]
        |=> tx_data_o[pin_mux_pkg::FIRST] ==
            $past(test_pattern_i[pin_mux_pkg::FIRST]))
        else $error("test pattern not on first transmit data");

    chk_idle_second: assert property (
        !cfg_b[pin_mux_pkg::TEST_MUX_BIT] &&
        !cfg_b[pin_mux_pkg::IDLE_FUNC_BIT] &&
        idle_table_hit_i[pin_mux_pkg::SECOND]
        |=> tx_data_o[pin_mux_pkg::SECOND] ==
            $past(idle_code_bit_i[pin_mux_pkg::SECOND]))
        else $error("idle code not inserted on second framer");

    chk_idle_insert: assert property (
        !cfg_a[pin_mux_pkg::TEST_MUX_BIT] &&
        !cfg_a[pin_mux_pkg::IDLE_FUNC_BIT] &&
        idle_table_hit_i[pin_mux_pkg::FIRST]
        |=> tx_data_o[pin_mux_pkg::FIRST] ==
            $past(idle_code_bit_i[pin_mux_pkg::FIRST]))
        else $error("idle code not inserted");

    chk_channel_loop: assert property (
        !cfg_a[pin_mux_pkg::TEST_MUX_BIT] &&
        cfg_a[pin_mux_pkg::IDLE_FUNC_BIT] &&
        idle_table_hit_i[pin_mux_pkg::FIRST]
        |=> tx_data_o[pin_mux_pkg::FIRST] ==
            $past(rx_serial_i[pin_mux_pkg::FIRST]))
        else $error("receive data not looped to channel");

    chk_clock_invert: assert property (
        rst_b_i |=> second_rx_clock_o ==
        ($past(second_rx_clock_in_i) ^ $past(cfg_b[pin_mux_pkg::RX_INV_BIT])))
        else $error("receive clock polarity wrong");

    chk_tx_clock_invert: assert property (
        rst_b_i |=> second_tx_clock_out_o ==
            ($past(second_tx_clock_src_i) ^
             $past(cfg_b[pin_mux_pkg::TX_INV_BIT])))
        else $error("transmit clock polarity wrong");

    chk_framer_route: assert property (
        cfg_b[pin_mux_pkg::FRAMER_DISC_BIT]
        |=> second_framer_in_o == $past(second_ext_data_i))
        else $error("framer link not broken");

    chk_framer_connect: assert property (
        rst_b_i && !cfg_b[pin_mux_pkg::FRAMER_DISC_BIT]
        |=> second_framer_in_o == $past(first_framer_out_i))
        else $error("first framer not routed to second");

    chk_read_back: assert property (
        rd_i && addr_i == pin_mux_pkg::ADDR_FIRST_CTRL
        |=> rdata_o == $past(cfg_a)
        ##1 ($past(rd_i) || rdata_o == pin_mux_pkg::READ_IDLE))
        else $error("read data wrong or held too long");

    chk_read_second: assert property (
        rd_i && addr_i == pin_mux_pkg::ADDR_SECOND_CTRL
        |=> rdata_o == $past(cfg_b))
        else $error("second register read back wrong");

    chk_read_unmapped: assert property (
        rd_i && addr_i != pin_mux_pkg::ADDR_FIRST_CTRL &&
        addr_i != pin_mux_pkg::ADDR_SECOND_CTRL
        |=> rdata_o == pin_mux_pkg::READ_IDLE)
        else $error("unmapped read not idle");

    cov_alarm_force: cover property (
        !cfg_a[pin_mux_pkg::ALARM_FORCE_BIT]
        ##1 cfg_a[pin_mux_pkg::ALARM_FORCE_BIT]);
    cov_falling_line: cover property (
        cfg_a[pin_mux_pkg::LINE_EDGE_BIT] && line_edge);
    cov_loopback: cover property (
        cfg_b[pin_mux_pkg::IDLE_FUNC_BIT]
        && idle_table_hit_i[pin_mux_pkg::SECOND]);
    cov_link_pins: cover property (
        cfg_a[pin_mux_pkg::PIN_FUNC_BIT] && cfg_b[pin_mux_pkg::PIN_FUNC_BIT]);
    cov_write_read: cover property (
        wr_i && addr_i == pin_mux_pkg::ADDR_SECOND_CTRL ##1 rd_i);

endmodule // framer_pin_and_mux_control
`default_nettype wire

// *** tb/test_framer_pin_and_mux_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_framer_pin_and_mux_control;
    localparam logic [7:0] ra = pin_mux_pkg::ADDR_FIRST_CTRL;
    localparam logic [7:0] rb = pin_mux_pkg::ADDR_SECOND_CTRL;
    logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic line_side_clock_i = 1'b0, line_nrz_src_i = 1'b0;
    logic line_sync_src_i = 1'b0, payload_clock_i = 1'b0;
    logic payload_data_i = 1'b0, liu_rx_data_i = 1'b1;
    logic first_ext_data_i = 1'b0, first_framer_out_i = 1'b1;
    logic second_ext_data_i = 1'b0, second_rx_clock_in_i = 1'b1;
    logic second_tx_clock_src_i = 1'b0;
    logic line_side_nrz_output_o, line_side_frame_sync_o, payload_sample_o;
    logic first_framer_line_o, second_framer_in_o;
    logic second_rx_clock_o, second_tx_clock_out_o;
    logic [1:0] tx_payload_i = 2'h0, test_pattern_i = 2'h0;
    logic [1:0] idle_table_hit_i = 2'h0, idle_code_bit_i = 2'h0;
    logic [1:0] rx_serial_i = 2'h0, tx_data_o, sv;
    logic [1:0][3:0] channel_pins_i = 8'h3C, link_pins_i = 8'hC3;
    logic [1:0][3:0] shared_pins_o;
    int n_errors = 0;
    int total_checks = 0;

    framer_pin_and_mux_control u_dut (.clk_i, .rst_b_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .line_side_clock_i, .line_nrz_src_i,
        .line_sync_src_i, .line_side_nrz_output_o, .line_side_frame_sync_o,
        .payload_clock_i, .payload_data_i, .payload_sample_o, .liu_rx_data_i,
        .first_ext_data_i, .first_framer_line_o, .first_framer_out_i,
        .second_ext_data_i, .second_framer_in_o, .second_rx_clock_in_i,
        .second_tx_clock_src_i, .second_rx_clock_o, .second_tx_clock_out_o,
        .tx_payload_i, .test_pattern_i, .idle_table_hit_i, .idle_code_bit_i,
        .rx_serial_i, .tx_data_o, .channel_pins_i, .link_pins_i,
        .shared_pins_o);

    always #10 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", exp, rdata_o);
    endtask

    // Back-to-back reads: each word stands only in its own cycle
    task automatic rd_pair(input logic [7:0] a0, input logic [7:0] e0,
                           input logic [7:0] a1, input logic [7:0] e1);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a0;
        @(posedge clk_i);
        addr_i <= a1;
        #1;
        chk("rdata first", e0, rdata_o);
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata second", e1, rdata_o);
    endtask

    // Edge detection needs two samples, so allow a few cycles to settle
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic cfg(input logic [7:0] a, input logic [7:0] b);
        wr_reg(ra, a);
        wr_reg(rb, b);
        settle();
    endtask

    // Data first, then the clock level one cycle later
    task automatic clk_step(input bit pay, input logic c, input logic s,
                            input logic [1:0] exp);
        @(posedge clk_i);
        if (pay) begin
            payload_data_i <= s;
        end else begin
            line_nrz_src_i <= s;
            line_sync_src_i <= s;
        end
        @(posedge clk_i);
        if (pay) begin
            payload_clock_i <= c;
        end else begin
            line_side_clock_i <= c;
        end
        settle();
        if (pay) begin
            chk("payload sample", {6'h0, exp}, {7'h0, payload_sample_o});
        end else begin
            chk("line nrz sync", {6'h0, exp},
                {6'h0, line_side_nrz_output_o, line_side_frame_sync_o});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd_reg(ra, pin_mux_pkg::CTRL_RESET);
        rd_reg(rb, pin_mux_pkg::CTRL_RESET);
        wr_reg(ra, 8'hA5);
        rd_reg(ra, 8'hA5);
        wr_reg(rb, 8'hC6);
        rd_reg(rb, 8'hC6);
        wr_reg(8'h12, 8'hFF);
        rd_reg(8'h12, 8'h00);
        rd_reg(ra, 8'hA5);
        rd_reg(rb, 8'hC6);
        rd_pair(ra, 8'hA5, rb, 8'hC6);
        @(posedge clk_i);
        #1;
        chk("rdata idle", pin_mux_pkg::READ_IDLE, rdata_o);
        $display("test registers done");
        cfg(8'h00, 8'h00);
        clk_step(0, 1'b1, 1'b1, 2'b11);
        clk_step(0, 1'b0, 1'b0, 2'b11);
        cfg(8'h80, 8'h00);
        clk_step(0, 1'b1, 1'b0, 2'b11);
        clk_step(0, 1'b0, 1'b0, 2'b00);
        cfg(8'h90, 8'h00);
        clk_step(0, 1'b1, 1'b1, 2'b10);
        clk_step(0, 1'b0, 1'b1, 2'b10);
        $display("test line side done");
        cfg(8'h00, 8'h00);
        clk_step(1, 1'b1, 1'b1, 2'b00);
        clk_step(1, 1'b0, 1'b1, 2'b01);
        cfg(8'h40, 8'h00);
        clk_step(1, 1'b1, 1'b0, 2'b00);
        clk_step(1, 1'b0, 1'b1, 2'b00);
        $display("test payload done");
        for (int k = 0; k < 4; k++) begin
            cfg({5'h0, k[0], 2'h0}, {k[0], k[1], 3'h0, k[1], 2'h0});
            chk("routes", {4'h0, ~k[0], ~k[1], ~k[0], k[1]},
                {4'h0, first_framer_line_o, second_framer_in_o,
                 second_rx_clock_o, second_tx_clock_out_o});
            cfg({6'h0, k[0], 1'b0}, {6'h0, k[1], 1'b0});
            chk("shared pins", {k[1] ? 4'hC : 4'h3, k[0] ? 4'h3 : 4'hC},
                shared_pins_o);
        end
        $display("test routes and pins done");
        // Selected source gets one value, every other source its inverse
        for (int m = 0; m < 16; m++) begin
            sv = {~m[0], m[0]};
            @(posedge clk_i);
            test_pattern_i <= m[3] ? sv : ~sv;
            tx_payload_i <= (!m[3] && !m[1]) ? sv : ~sv;
            idle_code_bit_i <= (!m[3] && m[1] && !m[2]) ? sv : ~sv;
            rx_serial_i <= (!m[3] && m[1] && m[2]) ? sv : ~sv;
            idle_table_hit_i <= {m[1], m[1]};
            cfg({2'h0, m[3], 4'h0, m[2]}, {2'h0, m[3], 4'h0, m[2]});
            chk("tx data", {6'h0, sv}, {6'h0, tx_data_o});
        end
        $display("test transmit select done");
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        give_verdict();
    end
endmodule // test_framer_pin_and_mux_control
`default_nettype wire
